// ---- design/nlrs_pkg.sv ----
package nlrs_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ = 10;
    localparam int T_WB_NS = 100;
    localparam int T_CCS_NS = 300;
    localparam int T_WHR_NS = 120;
    localparam int WB_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
    localparam int CCS_CYC = (T_CCS_NS * CLK_MHZ + 999) / 1000;
    localparam int WHR_CYC = (T_WHR_NS * CLK_MHZ + 999) / 1000;

    // ****************************************
    // command bytes
    // ****************************************
    localparam logic [7:0] CMD_READ_1 = 8'h00;
    localparam logic [7:0] CMD_READ_2 = 8'h30;
    localparam logic [7:0] CMD_QUEUE = 8'h32;
    localparam logic [7:0] CMD_CACHE = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] CMD_COL = 8'h05;
    localparam logic [7:0] CMD_COL_ENH = 8'h06;
    localparam logic [7:0] CMD_COL_END = 8'he0;
    localparam logic [7:0] CMD_RESET = 8'hff;

    // ****************************************
    // address layout
    // ****************************************
    localparam logic [2:0] NADR_FULL = 3'h5;
    localparam logic [2:0] NADR_COL = 3'h2;
    localparam logic [2:0] NADR_ROW = 3'h3;
    localparam int ADR_W = 40;
    localparam int ROW_LSB = 16;
    localparam int ROW_W = 24;
    localparam int LEN_W = 16;
    localparam logic [LEN_W-1:0] STATUS_LEN = 16'h0001;

    // ****************************************
    // operations, waits, states
    // ****************************************
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_QUEUE = 4'h1, OP_RAND = 4'h2, OP_SEQ = 4'h3,
        OP_LAST = 4'h4, OP_MODE = 4'h5, OP_STAT = 4'h6, OP_STATE = 4'h7,
        OP_COL = 4'h8, OP_COLE = 4'h9, OP_DATA = 4'ha, OP_RESET = 4'hb
    } nlrs_op_t;

    typedef enum logic [1:0] {
        W_NONE = 2'h0, W_BUSY = 2'h1, W_CCS = 2'h2, W_WHR = 2'h3
    } nlrs_wait_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_CMD1 = 3'h1, S_ADDR = 3'h3, S_CMD2 = 3'h2,
        S_WAIT = 3'h6, S_BUSY = 3'h7, S_DATA = 3'h5
    } nlrs_state_t;

endpackage

// ---- design/nlrs_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module nlrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic en_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic [AW:0] fill;
    logic push;
    logic pop;

    assign fill = wr_r - rd_r;
    assign in_ready_o = fill != (AW+1)'(DEPTH);
    assign out_valid_o = fill != '0;
    assign push = en_i && in_valid_i && in_ready_o;
    assign pop = en_i && out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_r[AW-1:0]];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r + 1'b1 == (AW+1)'(2*DEPTH)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r + 1'b1 == (AW+1)'(2*DEPTH)) ? '0 : rd_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ---- design/nlrs_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module nlrs_host #(
    parameter int LUN_LSB = 23,
    parameter int LUN_W = 1,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    input wire logic OP_VALID_I,
    output logic OP_READY_O,
    output logic OP_REFUSED_O,
    input wire logic [3:0] OP_CODE_I,
    input wire logic [nlrs_pkg::ADR_W-1:0] OP_ADDR_I,
    input wire logic [nlrs_pkg::LEN_W-1:0] OP_LEN_I,
    output logic [7:0] RD_DATA_O,
    output logic RD_VALID_O,
    input wire logic RD_READY_I,
    output logic DIE_RDY_O,
    output logic DIE_ARDY_O,
    output logic NAND_CE_N_O,
    output logic NAND_CLE_O,
    output logic NAND_ALE_O,
    output logic NAND_WE_N_O,
    output logic NAND_RE_N_O,
    input wire logic [7:0] NAND_DQ_I,
    output logic [7:0] NAND_DQ_O,
    output logic NAND_DQ_OE_O,
    input wire logic NAND_RB_N_I
);
    // ****************************************
    // ready/busy synchroniser
    // ****************************************
    logic rb_s1_r, rb_s2_r, rb_s3_r, rb_q_r, rb_q_nxt;
    assign rb_q_nxt = (rb_s2_r == rb_s3_r) ? rb_s3_r : rb_q_r;
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rb_s1_r <= 1'b1;
            rb_s2_r <= 1'b1;
            rb_s3_r <= 1'b1;
            rb_q_r <= 1'b1;
        end else if (CE_I) begin
            rb_s1_r <= NAND_RB_N_I;
            rb_s2_r <= rb_s1_r;
            rb_s3_r <= rb_s2_r;
            rb_q_r <= rb_q_nxt;
        end
    end

    // ****************************************
    // die state tracking and command legality
    // ****************************************
    nlrs_pkg::nlrs_state_t state_r, state_nxt;
    logic loaded_r, cache_r, queued_r, stsel_r;
    logic loaded_nxt, cache_nxt, queued_nxt, stsel_nxt;
    logic [nlrs_pkg::ROW_W-1:0] row_r, row_nxt, row_inc, op_row;
    logic idle, legal, go, seq_cross, lun_ok;
    logic op_read, op_queue, op_rand, op_seq, op_last, op_mode;
    logic op_stat, op_state, op_col, op_cole, op_data, op_reset;

    assign op_read = OP_CODE_I == nlrs_pkg::OP_READ;
    assign op_queue = OP_CODE_I == nlrs_pkg::OP_QUEUE;
    assign op_rand = OP_CODE_I == nlrs_pkg::OP_RAND;
    assign op_seq = OP_CODE_I == nlrs_pkg::OP_SEQ;
    assign op_last = OP_CODE_I == nlrs_pkg::OP_LAST;
    assign op_mode = OP_CODE_I == nlrs_pkg::OP_MODE;
    assign op_stat = OP_CODE_I == nlrs_pkg::OP_STAT;
    assign op_state = OP_CODE_I == nlrs_pkg::OP_STATE;
    assign op_col = OP_CODE_I == nlrs_pkg::OP_COL;
    assign op_cole = OP_CODE_I == nlrs_pkg::OP_COLE;
    assign op_data = OP_CODE_I == nlrs_pkg::OP_DATA;
    assign op_reset = OP_CODE_I == nlrs_pkg::OP_RESET;

    assign op_row = OP_ADDR_I[nlrs_pkg::ROW_LSB +: nlrs_pkg::ROW_W];
    assign row_inc = row_r + 1'b1;
    assign seq_cross = row_inc[LUN_LSB +: LUN_W] != row_r[LUN_LSB +: LUN_W];
    assign lun_ok = op_row[LUN_LSB +: LUN_W] == row_r[LUN_LSB +: LUN_W];
    assign idle = state_r == nlrs_pkg::S_IDLE;
    // busy states never reach here: ops are taken only when idle
    assign legal = op_stat || op_state || op_reset
        || (op_read && !cache_r)
        || op_queue
        || (op_rand && loaded_r && lun_ok)
        || (op_seq && loaded_r && !queued_r && !seq_cross)
        || (op_last && cache_r && !queued_r)
        || ((op_mode || op_col || op_cole || op_data) && loaded_r && !queued_r);
    assign OP_READY_O = idle;
    assign OP_REFUSED_O = OP_VALID_I && idle && !legal;
    assign go = CE_I && OP_VALID_I && idle && legal;

    assign loaded_nxt = !go ? loaded_r : (op_reset ? 1'b0 : (op_read || loaded_r));
    assign cache_nxt = !go ? cache_r : ((op_rand || op_seq) ? 1'b1
        : ((op_reset || op_last || op_read) ? 1'b0 : cache_r));
    assign queued_nxt = !go ? queued_r : (op_queue ? 1'b1 : ((op_read || op_rand || op_reset) ? 1'b0 : queued_r));
    assign stsel_nxt = !go ? stsel_r : ((op_stat || op_state) ? 1'b1
        : ((op_mode || op_data || op_read || op_reset) ? 1'b0 : stsel_r));
    assign row_nxt = !go ? row_r : ((op_read || op_rand) ? op_row : (op_seq ? row_inc : row_r));
    assign DIE_RDY_O = state_r != nlrs_pkg::S_BUSY;
    assign DIE_ARDY_O = DIE_RDY_O && !cache_r;

    // ****************************************
    // bus sequence set-up per operation
    // ****************************************
    logic [7:0] s_c1, s_c2;
    logic s_hc1, s_hc2;
    logic [2:0] s_nadr;
    logic [nlrs_pkg::ADR_W-1:0] s_adr;
    nlrs_pkg::nlrs_wait_t s_wait;
    logic [nlrs_pkg::LEN_W-1:0] s_len;
    always_comb begin
        s_c1 = nlrs_pkg::CMD_READ_1;
        s_c2 = nlrs_pkg::CMD_READ_2;
        s_hc1 = 1'b1;
        s_hc2 = 1'b0;
        s_nadr = '0;
        s_adr = OP_ADDR_I;
        s_wait = nlrs_pkg::W_BUSY;
        s_len = '0;
        unique case (OP_CODE_I)
            nlrs_pkg::OP_READ: begin
                s_hc2 = 1'b1;
                s_nadr = nlrs_pkg::NADR_FULL;
            end
            nlrs_pkg::OP_QUEUE, nlrs_pkg::OP_RAND: begin
                s_c2 = op_queue ? nlrs_pkg::CMD_QUEUE : nlrs_pkg::CMD_CACHE;
                s_hc2 = 1'b1;
                s_nadr = nlrs_pkg::NADR_FULL;
            end
            nlrs_pkg::OP_SEQ: s_c1 = nlrs_pkg::CMD_CACHE;
            nlrs_pkg::OP_LAST: s_c1 = nlrs_pkg::CMD_CACHE_LAST;
            nlrs_pkg::OP_RESET: s_c1 = nlrs_pkg::CMD_RESET;
            nlrs_pkg::OP_MODE: s_wait = nlrs_pkg::W_NONE;
            nlrs_pkg::OP_STAT, nlrs_pkg::OP_STATE: begin
                s_c1 = op_stat ? nlrs_pkg::CMD_STATUS : nlrs_pkg::CMD_STATUS_ENH;
                s_nadr = op_stat ? 3'h0 : nlrs_pkg::NADR_ROW;
                s_adr = OP_ADDR_I >> nlrs_pkg::ROW_LSB;
                s_wait = nlrs_pkg::W_WHR;
                s_len = nlrs_pkg::STATUS_LEN;
            end
            nlrs_pkg::OP_COL, nlrs_pkg::OP_COLE: begin
                s_c1 = op_col ? nlrs_pkg::CMD_COL : nlrs_pkg::CMD_COL_ENH;
                s_c2 = nlrs_pkg::CMD_COL_END;
                s_hc2 = 1'b1;
                s_nadr = op_col ? nlrs_pkg::NADR_COL : nlrs_pkg::NADR_FULL;
                s_wait = nlrs_pkg::W_CCS;
            end
            nlrs_pkg::OP_DATA: begin
                s_hc1 = stsel_r;
                s_wait = nlrs_pkg::W_NONE;
                s_len = OP_LEN_I;
            end
            default: s_hc1 = 1'b0;
        endcase
    end

    // ****************************************
    // pin sequencer
    // ****************************************
    logic phase_r, phase_nxt, seen_lo_r, seen_lo_nxt;
    logic hc2_r, hc2_nxt;
    logic [7:0] c1_r, c1_nxt, c2_r, c2_nxt, cnt_r, cnt_nxt;
    logic [2:0] nadr_r, nadr_nxt;
    logic [nlrs_pkg::ADR_W-1:0] adr_r, adr_nxt;
    nlrs_pkg::nlrs_wait_t wait_r, wait_nxt;
    logic [nlrs_pkg::LEN_W-1:0] len_r, len_nxt;
    nlrs_pkg::nlrs_state_t after, start;
    logic fifo_ready, push, wcyc;
    logic [7:0] s_cnt;

    assign s_cnt = (s_wait == nlrs_pkg::W_CCS) ? 8'(nlrs_pkg::CCS_CYC)
        : ((s_wait == nlrs_pkg::W_WHR) ? 8'(nlrs_pkg::WHR_CYC) : 8'(nlrs_pkg::WB_CYC));
    assign after = (wait_r != nlrs_pkg::W_NONE) ? nlrs_pkg::S_WAIT
        : ((len_r != '0) ? nlrs_pkg::S_DATA : nlrs_pkg::S_IDLE);
    assign start = s_hc1 ? nlrs_pkg::S_CMD1 : ((s_len != '0) ? nlrs_pkg::S_DATA : nlrs_pkg::S_IDLE);
    assign wcyc = state_r == nlrs_pkg::S_CMD1 || state_r == nlrs_pkg::S_ADDR || state_r == nlrs_pkg::S_CMD2;
    assign push = CE_I && state_r == nlrs_pkg::S_DATA && !phase_r && fifo_ready;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            nlrs_pkg::S_IDLE: state_nxt = go ? start : state_r;
            nlrs_pkg::S_CMD1: if (phase_r) begin
                state_nxt = (nadr_r != '0) ? nlrs_pkg::S_ADDR : (hc2_r ? nlrs_pkg::S_CMD2 : after);
            end
            nlrs_pkg::S_ADDR: if (phase_r && nadr_r == 3'h1) begin
                state_nxt = hc2_r ? nlrs_pkg::S_CMD2 : after;
            end
            nlrs_pkg::S_CMD2: if (phase_r) begin
                state_nxt = after;
            end
            nlrs_pkg::S_WAIT: if (cnt_r == '0) begin
                state_nxt = (wait_r == nlrs_pkg::W_BUSY) ? nlrs_pkg::S_BUSY
                    : ((len_r != '0) ? nlrs_pkg::S_DATA : nlrs_pkg::S_IDLE);
            end
            nlrs_pkg::S_BUSY: if (seen_lo_r && rb_q_r) begin
                state_nxt = (len_r != '0) ? nlrs_pkg::S_DATA : nlrs_pkg::S_IDLE;
            end
            nlrs_pkg::S_DATA: if (phase_r && len_r == '0) begin
                state_nxt = nlrs_pkg::S_IDLE;
            end
            default: state_nxt = nlrs_pkg::S_IDLE;
        endcase
    end

    assign phase_nxt = (wcyc || (state_r == nlrs_pkg::S_DATA && (phase_r || fifo_ready))) ? !phase_r : 1'b0;
    assign c1_nxt = go ? s_c1 : c1_r;
    assign c2_nxt = go ? s_c2 : c2_r;
    assign hc2_nxt = go ? s_hc2 : hc2_r;
    assign wait_nxt = go ? s_wait : wait_r;
    assign nadr_nxt = go ? s_nadr : ((state_r == nlrs_pkg::S_ADDR && phase_r) ? nadr_r - 1'b1 : nadr_r);
    assign adr_nxt = go ? s_adr : ((state_r == nlrs_pkg::S_ADDR && phase_r) ? adr_r >> 8 : adr_r);
    assign len_nxt = go ? s_len : (push ? len_r - 1'b1 : len_r);
    assign cnt_nxt = go ? s_cnt : ((state_r == nlrs_pkg::S_WAIT && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
    assign seen_lo_nxt = (state_r == nlrs_pkg::S_BUSY) ? (seen_lo_r || !rb_q_r) : 1'b0;

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r <= nlrs_pkg::S_IDLE;
            wait_r <= nlrs_pkg::W_NONE;
            {phase_r, seen_lo_r, hc2_r} <= 3'h0;
            {c1_r, c2_r, cnt_r, nadr_r} <= '0;
            {adr_r, len_r, row_r} <= '0;
            {loaded_r, cache_r, queued_r, stsel_r} <= 4'h0;
        end else if (CE_I) begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            {phase_r, seen_lo_r, hc2_r} <= {phase_nxt, seen_lo_nxt, hc2_nxt};
            {c1_r, c2_r, cnt_r, nadr_r} <= {c1_nxt, c2_nxt, cnt_nxt, nadr_nxt};
            {adr_r, len_r, row_r} <= {adr_nxt, len_nxt, row_nxt};
            {loaded_r, cache_r, queued_r, stsel_r} <= {loaded_nxt, cache_nxt, queued_nxt, stsel_nxt};
        end
    end

    assign NAND_CE_N_O = idle;
    assign NAND_CLE_O = state_r == nlrs_pkg::S_CMD1 || state_r == nlrs_pkg::S_CMD2;
    assign NAND_ALE_O = state_r == nlrs_pkg::S_ADDR;
    assign NAND_WE_N_O = !(wcyc && !phase_r);
    assign NAND_DQ_OE_O = wcyc;
    assign NAND_DQ_O = !wcyc ? 8'h00 : (NAND_ALE_O ? adr_r[7:0]
        : ((state_r == nlrs_pkg::S_CMD1) ? c1_r : c2_r));
    assign NAND_RE_N_O = !(state_r == nlrs_pkg::S_DATA && !phase_r && fifo_ready);

    // ****************************************
    // read data buffer
    // ****************************************
    nlrs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .en_i(CE_I),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i(NAND_DQ_I),
        .out_valid_o(RD_VALID_O),
        .out_ready_i(RD_READY_I),
        .out_data_o(RD_DATA_O)
    );

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    a_read_cycles: assert property (go && op_read && CE_I |=> (NAND_CLE_O && NAND_DQ_O == nlrs_pkg::CMD_READ_1)
        ##2 NAND_ALE_O [*8] ##1 NAND_ALE_O ##1 NAND_ALE_O ##1 (NAND_CLE_O && NAND_DQ_O == nlrs_pkg::CMD_READ_2))
        else $error("page read cycle order wrong");
    a_col_cycles: assert property (go && op_col |=> (NAND_CLE_O && NAND_DQ_O == nlrs_pkg::CMD_COL)
        ##2 NAND_ALE_O [*4] ##1 (NAND_CLE_O && NAND_DQ_O == nlrs_pkg::CMD_COL_END))
        else $error("column change cycle order wrong");
    a_busy_no_ops: assert property (state_r == nlrs_pkg::S_BUSY |-> !OP_READY_O && NAND_WE_N_O)
        else $error("command offered while die busy");
    a_cache_no_read: assert property (OP_VALID_I && idle && cache_r && op_read |-> OP_REFUSED_O ##1 idle)
        else $error("page read started during cache read");
    a_busy_exit_ready: assert property (state_r == nlrs_pkg::S_BUSY ##1 state_r != nlrs_pkg::S_BUSY |-> $past(rb_q_r))
        else $error("left busy wait before ready");
    a_seq_same_die: assert property (go && op_seq |=> row_r[LUN_LSB +: LUN_W] == $past(row_r[LUN_LSB +: LUN_W]))
        else $error("sequential cache crossed die");
    a_rand_same_die: assert property (go && op_rand |=> row_r[LUN_LSB +: LUN_W] == $past(row_r[LUN_LSB +: LUN_W]))
        else $error("random cache changed die");
    a_status_then_mode: assert property (go && op_data && stsel_r |=> NAND_CLE_O && NAND_DQ_O == nlrs_pkg::CMD_READ_1)
        else $error("data read after status without read mode");
    a_refused_stable: assert property (OP_REFUSED_O && CE_I |=> idle && $stable(cache_r) && $stable(row_r))
        else $error("refused command changed state");
    a_fifo_stall: assert property (state_r == nlrs_pkg::S_DATA && !fifo_ready |-> NAND_RE_N_O)
        else $error("read strobe while buffer full");
    a_queue_then_read: assert property (go && op_queue |=> queued_r && NAND_CLE_O
        && NAND_DQ_O == nlrs_pkg::CMD_READ_1 ##12 (NAND_CLE_O && NAND_DQ_O == nlrs_pkg::CMD_QUEUE))
        else $error("plane queue cycle order wrong");

    c_page_read: cover property (go && op_read ##[1:300] state_r == nlrs_pkg::S_BUSY);
    c_seq_cache: cover property (go && op_seq ##[1:300] cache_r && idle);
    c_cache_last: cover property (go && op_last ##[1:300] DIE_ARDY_O && idle);
    c_data_stall: cover property (state_r == nlrs_pkg::S_DATA && !fifo_ready);
endmodule
`default_nettype wire

// ---- dv/nlrs_die_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// behavioural die answering the host pins
// ****************************************
module nlrs_die_model #(
    parameter int TR_CYC = 20,
    parameter int TRCBSY_CYC = 6
) (
    input wire logic clk_i,
    input wire logic ce_n_i,
    input wire logic cle_i,
    input wire logic ale_i,
    input wire logic we_n_i,
    input wire logic re_n_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic rb_n_o
);
    logic [7:0] cmd_r = 8'h00;
    logic [7:0] last_r = 8'h00;
    logic [39:0] adr_r = 40'h0;
    logic [2:0] adr_n = 3'h0;
    logic [15:0] col_r = 16'h0, creg_r = 16'h0, dreg_r = 16'h0;
    logic stat_r = 1'b0, ardy_r = 1'b1, re_prev = 1'b1;
    int busy_r = 0;
    wire logic [7:0] byte_w;
    assign byte_w = stat_r ? {1'b0, busy_r == 0, ardy_r && busy_r == 0, 5'h00} : creg_r[7:0] + col_r[7:0];
    assign rb_n_o = busy_r == 0;
    // released bus shows the inverse of the last byte
    assign dq_o = re_n_i ? ~last_r : byte_w;

    always @(negedge clk_i) begin
        re_prev <= re_n_i;
        if (!re_prev && re_n_i) begin
            last_r <= byte_w;
            if (!stat_r) begin
                col_r <= col_r + 16'h1;
            end
        end
        if (busy_r > 0) begin
            busy_r <= busy_r - 1;
        end
        if (!ce_n_i && !we_n_i && cle_i) begin
            cmd_r <= dq_i;
            case (dq_i)
                8'h00, 8'h05, 8'h06: begin
                    adr_n <= 3'h0;
                    stat_r <= 1'b0;
                end
                8'h70, 8'h78: begin
                    adr_n <= 3'h0;
                    stat_r <= 1'b1;
                end
                8'h30: begin
                    creg_r <= adr_r[31:16];
                    dreg_r <= adr_r[31:16];
                    col_r <= adr_r[15:0];
                    busy_r <= TR_CYC;
                end
                8'h32: busy_r <= TRCBSY_CYC;
                8'h31: begin
                    creg_r <= dreg_r;
                    dreg_r <= (cmd_r == 8'h00 && adr_n == 3'h5) ? adr_r[31:16] : dreg_r + 16'h1;
                    col_r <= 16'h0;
                    ardy_r <= 1'b0;
                    busy_r <= TRCBSY_CYC;
                end
                8'h3f: begin
                    creg_r <= dreg_r;
                    col_r <= 16'h0;
                    ardy_r <= 1'b1;
                    busy_r <= TRCBSY_CYC;
                end
                8'he0: begin
                    col_r <= adr_r[15:0];
                    if (cmd_r == 8'h06) begin
                        creg_r <= adr_r[31:16];
                    end
                end
                8'hff: begin
                    stat_r <= 1'b0;
                    ardy_r <= 1'b1;
                    busy_r <= TRCBSY_CYC;
                end
                default: ;
            endcase
        end else if (!ce_n_i && !we_n_i && ale_i) begin
            adr_r[adr_n*8 +: 8] <= dq_i;
            adr_n <= adr_n + 3'h1;
        end
    end
endmodule
`default_nettype wire

// ---- dv/nlrs_host_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module nlrs_host_tb;
    typedef struct packed {
        logic [3:0] op;
        logic [39:0] addr;
        logic [7:0] n;
        logic rf;
        logic [7:0] b0;
        logic inc;
        logic [1:0] ra;
    } nlrs_row_t;
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic CE_I = 1'b1;
    logic OP_VALID_I = 1'b0;
    logic RD_READY_I = 1'b1;
    logic [3:0] OP_CODE_I = 4'h0;
    logic [39:0] OP_ADDR_I = 40'h0;
    logic [15:0] OP_LEN_I = 16'h0;
    logic OP_READY_O, OP_REFUSED_O, RD_VALID_O, DIE_RDY_O, DIE_ARDY_O, rb_n;
    logic NAND_CE_N_O, NAND_CLE_O, NAND_ALE_O, NAND_WE_N_O, NAND_RE_N_O, NAND_DQ_OE_O;
    logic [7:0] RD_DATA_O, NAND_DQ_O, die_dq;
    wire logic [7:0] dq_w;
    logic [7:0] q[$];
    int fails = 0;
    int total_checks = 0;
    nlrs_row_t rows [24] = '{
        '{4'hb, 40'h0, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'h0, 40'h0000010010, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'ha, 40'h0, 8'h04, 1'b0, 8'h11, 1'b1, 2'h3},
        '{4'h8, 40'h0000000020, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'ha, 40'h0, 8'h02, 1'b0, 8'h21, 1'b1, 2'h3},
        '{4'h3, 40'h0, 8'h00, 1'b0, 8'h00, 1'b0, 2'h2},
        '{4'ha, 40'h0, 8'h03, 1'b0, 8'h01, 1'b1, 2'h2},
        '{4'h0, 40'h0000010010, 8'h00, 1'b1, 8'h00, 1'b0, 2'h2},
        '{4'h3, 40'h0, 8'h00, 1'b0, 8'h00, 1'b0, 2'h2},
        '{4'ha, 40'h0, 8'h02, 1'b0, 8'h02, 1'b1, 2'h2},
        '{4'h2, 40'h0000050033, 8'h00, 1'b0, 8'h00, 1'b0, 2'h2},
        '{4'ha, 40'h0, 8'h01, 1'b0, 8'h03, 1'b1, 2'h2},
        '{4'h4, 40'h0, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'ha, 40'h0, 8'h02, 1'b0, 8'h05, 1'b1, 2'h3},
        '{4'h6, 40'h0, 8'h01, 1'b0, 8'h60, 1'b0, 2'h3},
        '{4'h5, 40'h0, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'ha, 40'h0, 8'h02, 1'b0, 8'h07, 1'b1, 2'h3},
        '{4'h1, 40'h0000080000, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'h0, 40'h0000090004, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'ha, 40'h0, 8'h02, 1'b0, 8'h0d, 1'b1, 2'h3},
        '{4'h9, 40'h0000080006, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3},
        '{4'ha, 40'h0, 8'h01, 1'b0, 8'h0e, 1'b1, 2'h3},
        '{4'h7, 40'h0000090000, 8'h01, 1'b0, 8'h60, 1'b0, 2'h3},
        '{4'h4, 40'h0, 8'h00, 1'b1, 8'h00, 1'b0, 2'h3}};

    assign dq_w = NAND_DQ_OE_O ? NAND_DQ_O : die_dq;
    always #50 CLK_I = ~CLK_I;
    always @(posedge CLK_I) if (RD_VALID_O && RD_READY_I) q.push_back(RD_DATA_O);

    nlrs_host i_nlrs_host (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .OP_VALID_I(OP_VALID_I),
        .OP_READY_O(OP_READY_O), .OP_REFUSED_O(OP_REFUSED_O), .OP_CODE_I(OP_CODE_I), .OP_ADDR_I(OP_ADDR_I),
        .OP_LEN_I(OP_LEN_I), .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .RD_READY_I(RD_READY_I),
        .DIE_RDY_O(DIE_RDY_O), .DIE_ARDY_O(DIE_ARDY_O), .NAND_CE_N_O(NAND_CE_N_O), .NAND_CLE_O(NAND_CLE_O),
        .NAND_ALE_O(NAND_ALE_O), .NAND_WE_N_O(NAND_WE_N_O), .NAND_RE_N_O(NAND_RE_N_O), .NAND_DQ_I(dq_w),
        .NAND_DQ_O(NAND_DQ_O), .NAND_DQ_OE_O(NAND_DQ_OE_O), .NAND_RB_N_I(rb_n));
    nlrs_die_model i_nlrs_die_model (.clk_i(CLK_I), .ce_n_i(NAND_CE_N_O), .cle_i(NAND_CLE_O),
        .ale_i(NAND_ALE_O), .we_n_i(NAND_WE_N_O), .re_n_i(NAND_RE_N_O), .dq_i(dq_w), .dq_o(die_dq),
        .rb_n_o(rb_n));

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic timeout(input string what);
        fails++;
        $display("Error %s expected done seen timeout", what);
        tally_and_finish();
    endtask
    task automatic wait_ready;
        @(negedge CLK_I);
        for (int k = 0; k < 3000 && OP_READY_O !== 1'b1; k++) @(negedge CLK_I);
        if (OP_READY_O !== 1'b1) timeout("op_ready");
    endtask
    task automatic run_op(input nlrs_row_t r, input logic wt);
        @(posedge CLK_I);
        OP_VALID_I <= 1'b1;
        OP_CODE_I <= r.op;
        OP_ADDR_I <= r.addr;
        OP_LEN_I <= {8'h00, r.n};
        @(negedge CLK_I);
        chk_bit("op_refused", r.rf, OP_REFUSED_O);
        @(posedge CLK_I);
        OP_VALID_I <= 1'b0;
        if (wt) wait_ready();
    endtask
    task automatic check_data(input nlrs_row_t r);
        for (int k = 0; k < 200 && q.size() < r.n; k++) @(negedge CLK_I);
        if (q.size() != r.n) timeout("rd_count");
        for (int i = 0; i < r.n; i++) chk_byte("rd_data", r.b0 + (r.inc ? i[7:0] : 8'h00), q.pop_front());
        chk_bit("die_rdy", r.ra[1], DIE_RDY_O);
        chk_bit("die_ardy", r.ra[0], DIE_ARDY_O);
    endtask
    task automatic do_reset;
        @(posedge CLK_I);
        RESET_I <= 1'b1;
        repeat (8) @(posedge CLK_I);
        @(negedge CLK_I);
        chk_bit("op_ready", 1'b1, OP_READY_O);
        chk_bit("ce_n", 1'b1, NAND_CE_N_O);
        chk_bit("rd_valid", 1'b0, RD_VALID_O);
        chk_bit("die_rdy", 1'b1, DIE_RDY_O);
        @(posedge CLK_I);
        RESET_I <= 1'b0;
        q.delete();
    endtask

    initial begin
        nlrs_row_t r;
        do_reset();
        foreach (rows[i]) begin
            run_op(rows[i], 1'b1);
            check_data(rows[i]);
        end
        // ****************************************
        // full fifo stalls the sequencer
        // ****************************************
        @(posedge CLK_I);
        RD_READY_I <= 1'b0;
        r = '{4'ha, 40'h0, 8'h0a, 1'b0, 8'h0f, 1'b1, 2'h3};
        run_op(r, 1'b0);
        repeat (40) @(posedge CLK_I);
        @(negedge CLK_I);
        chk_bit("op_ready", 1'b0, OP_READY_O);
        chk_bit("rd_valid", 1'b1, RD_VALID_O);
        @(posedge CLK_I);
        RD_READY_I <= 1'b1;
        wait_ready();
        check_data(r);
        do_reset();
        r = '{4'h3, 40'h0, 8'h00, 1'b1, 8'h00, 1'b0, 2'h3};
        run_op(r, 1'b1);
        r.op = 4'h4;
        run_op(r, 1'b1);
        check_data(r);
        r = '{4'h0, 40'h7fffff0000, 8'h00, 1'b0, 8'h00, 1'b0, 2'h3};
        run_op(r, 1'b1);
        r.rf = 1'b1;
        r.op = 4'h3;
        run_op(r, 1'b1);
        r.op = 4'h2;
        r.addr = 40'h8000000000;
        run_op(r, 1'b1);
        // ****************************************
        // low clock enable freezes op intake
        // ****************************************
        @(posedge CLK_I);
        CE_I <= 1'b0;
        r.op = 4'h6;
        r.rf = 1'b0;
        run_op(r, 1'b0);
        @(negedge CLK_I);
        chk_bit("op_ready", 1'b1, OP_READY_O);
        chk_bit("ce_n", 1'b1, NAND_CE_N_O);
        @(posedge CLK_I);
        CE_I <= 1'b1;
        check_data(r);
        tally_and_finish();
    end
endmodule
`default_nettype wire
